/* pll_counter_pkg.sv */
package pll_counter_pkg;
    // bus map: one word per register
    localparam logic [7:0] ofs_ctrl = 8'h00;        // loop control
    localparam logic [7:0] ofs_status = 8'h04;      // lock and live state
    localparam logic [7:0] ofs_prescale = 8'h08;    // pre-scale divide, 1..512
    localparam logic [7:0] ofs_multiply = 8'h0C;    // multiply divide, 1..512
    localparam logic [7:0] ofs_cascade = 8'h10;     // cascade bits, write-once
    localparam logic [7:0] ofs_out_base = 8'h20;    // output divider n at 0x20 + 4n
    localparam int num_outputs = 7;                 // output dividers per loop
    localparam int cnt_w = 9;                       // counter width for 1..512
    localparam int half_w = 8;                      // high/low field width, 1..256
    // ctrl fields
    localparam int ctrl_loop_reset_bit = 0;
    localparam int ctrl_ext_fb_bit = 1;
    localparam int ctrl_high_bw_bit = 2;
    // output divider word fields: low[7:0], high[15:8], delay[24:16], bypass[31]
    localparam int out_low_lsb = 0;
    localparam int out_high_lsb = 8;
    localparam int out_delay_lsb = 16;
    localparam int out_bypass_bit = 31;
    // reset values
    localparam logic [cnt_w-1:0] rst_divide = 9'h001;
    localparam logic [half_w-1:0] rst_half = 8'h00;  // field stores count-1
    localparam int lock_cycles = 16;                 // aligned feedback edges needed
    localparam logic [31:0] rst_ctrl = 32'h00000001; // loop held in reset
endpackage : pll_counter_pkg

/* post_divider.sv */
`timescale 1ns/1ns
module post_divider
    import pll_counter_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hold,
    // input clock as a one-cycle tick
    input wire logic tick_in,
    // settings (high and low fields hold count minus one)
    input wire logic [half_w-1:0] high_m1,
    input wire logic [half_w-1:0] low_m1,
    input wire logic [cnt_w-1:0] delay,
    input wire logic bypass,
    // divided output
    output logic clk_out,
    output logic tick_out
);
    logic [half_w-1:0] cnt_ff;   // counts within the current half
    logic [cnt_w-1:0] dly_ff;    // start delay still to run
    logic level_ff;              // current half: 1 high, 0 low
    logic started_ff;

    // divider walks high then low; the output tick marks each rising edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_ff <= 8'h00;
            dly_ff <= 9'h000;
            level_ff <= 1'b0;
            started_ff <= 1'b0;
            clk_out <= 1'b0;
            tick_out <= 1'b0;
        end else if (hold) begin
            // counters cleared and start delay reloaded while the loop is in reset
            cnt_ff <= 8'h00;
            dly_ff <= (delay == 9'h000) ? 9'h000 : delay - 9'h001;
            level_ff <= 1'b0;
            started_ff <= 1'b0;
            clk_out <= 1'b0;
            tick_out <= 1'b0;
        end else begin
            tick_out <= 1'b0;
            if (tick_in) begin
                if (bypass) begin
                    // divide by one: every input tick is an output edge; the level
                    // toggles only to stay visible on a registered pin
                    clk_out <= ~clk_out;
                    tick_out <= 1'b1;
                end else if (!started_ff) begin
                    // coarse phase: hold off start by delay-1 input cycles
                    if (dly_ff == 9'h000) begin
                        started_ff <= 1'b1;
                        level_ff <= 1'b1;
                        clk_out <= 1'b1;
                        tick_out <= 1'b1;
                        cnt_ff <= 8'h00;
                    end else begin
                        dly_ff <= dly_ff - 9'h001;
                    end
                end else if (level_ff && cnt_ff == high_m1) begin
                    // high count done, go low
                    level_ff <= 1'b0;
                    clk_out <= 1'b0;
                    cnt_ff <= 8'h00;
                end else if (!level_ff && cnt_ff == low_m1) begin
                    // low count done, period = high + low
                    level_ff <= 1'b1;
                    clk_out <= 1'b1;
                    tick_out <= 1'b1;
                    cnt_ff <= 8'h00;
                end else begin
                    cnt_ff <= cnt_ff + 8'h01;
                end
            end
        end
    end
endmodule : post_divider

/* pll_counter_synthesis.sv */
`timescale 1ns/1ns
module pll_counter_synthesis
    import pll_counter_pkg::*;
#(
    parameter int n_out = num_outputs
) (
    // system
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // loop clocks (oscillator modelled as a tick on hclk)
    input wire logic ref_clk,
    input wire logic fb_in,
    // clock outputs
    output logic [n_out-1:0] div_clk_out,
    output logic feedback_clock_out,
    output logic locked
);
    // registers
    logic [31:0] ctrl_ff;
    logic [cnt_w-1:0] pre_ff;
    logic [cnt_w-1:0] mult_ff;
    logic [n_out-1:0] cascade_ff;     // bit n: divider n clocked by divider n-1
    logic cascade_done_ff;            // first write locks the cascade map
    logic [31:0] out_cfg_ff [n_out];
    // address phase capture
    logic wr_pend_ff;
    logic [7:0] addr_ff;
    // synchronisers for pins
    logic [1:0] ref_sync_ff;
    logic [1:0] fb_sync_ff;
    logic ref_last_ff;
    logic fb_last_ff;
    // loop counters
    logic [cnt_w-1:0] pre_cnt_ff;
    logic [cnt_w-1:0] mult_cnt_ff;
    logic pre_tick_ff;
    logic fb_int_tick_ff;
    logic feedback_clock_out_ff;
    logic [4:0] lock_cnt_ff;
    logic [n_out-1:0] div_tick;
    logic [n_out-1:0] div_clk;

    // decode byte address to output divider index, or n_out when none
    function automatic int out_index(input logic [7:0] a);
        out_index = n_out;
        for (int i = 0; i < n_out; i++) begin
            if (a == ofs_out_base + 8'(4 * i)) begin
                out_index = i;
            end
        end
    endfunction : out_index

    // a divide setting is taken only inside 1..512; anything else leaves the old value
    function automatic logic div_ok(input logic [31:0] v);
        div_ok = (v != 32'h00000000) && (v <= 32'h00000200);
    endfunction : div_ok

    wire loop_hold = ctrl_ff[ctrl_loop_reset_bit];
    wire ext_fb = ctrl_ff[ctrl_ext_fb_bit];
    wire ref_rise = ref_sync_ff[1] & ~ref_last_ff;
    wire fb_rise = fb_sync_ff[1] & ~fb_last_ff;
    wire fb_tick = ext_fb ? fb_rise : fb_int_tick_ff;
    // oscillator stand-in: every hclk edge out of loop reset is one oscillator cycle
    wire osc_tick = ~loop_hold;
    // a divide of 512 is kept as zero in the nine-bit register; this view restores it
    wire [cnt_w:0] mult_val = {mult_ff == 9'h000, mult_ff};

    // ahb address phase: capture writes, answer with no wait states
    // only a write must wait for its data; reads are answered from the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            addr_ff <= 8'h00;
        end else if (hready) begin
            wr_pend_ff <= hsel & htrans[1] & hwrite;
            addr_ff <= haddr;
        end
    end

    // register writes in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff <= rst_ctrl;
            pre_ff <= rst_divide;
            mult_ff <= rst_divide;
            cascade_ff <= '0;
            cascade_done_ff <= 1'b0;
            for (int i = 0; i < n_out; i++) begin
                out_cfg_ff[i] <= 32'h00000000;
            end
        end else if (wr_pend_ff) begin
            unique case (addr_ff)
                ofs_ctrl: begin
                    // high bandwidth with external feedback is refused
                    ctrl_ff <= {29'h0, hwdata[ctrl_high_bw_bit] & ~hwdata[ctrl_ext_fb_bit],
                        hwdata[ctrl_ext_fb_bit], hwdata[ctrl_loop_reset_bit]};
                end
                ofs_prescale: begin
                    // 512 wraps to zero here, which the counter compare treats as 512
                    if (div_ok(hwdata)) pre_ff <= hwdata[8:0];
                end
                ofs_multiply: begin
                    // same range as the pre-scale divider
                    if (div_ok(hwdata)) mult_ff <= hwdata[8:0];
                end
                ofs_cascade: begin
                    // cascade map takes one write only, fixed like a config image
                    if (!cascade_done_ff) begin
                        cascade_ff <= {hwdata[n_out-1:1], 1'b0};
                        cascade_done_ff <= 1'b1;
                    end
                end
                default: begin
                    if (out_index(addr_ff) < n_out) begin
                        out_cfg_ff[out_index(addr_ff)] <= hwdata;
                    end
                end
            endcase
        end
    end

    // read mux, registered from the address phase for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (hready && hsel && htrans[1] && !hwrite) begin
                if (haddr == ofs_ctrl) hrdata <= ctrl_ff;
                else if (haddr == ofs_status) hrdata <= {29'h0, feedback_clock_out_ff, cascade_done_ff, locked};
                // a stored zero stands for 512, so bit 9 is rebuilt for software
                else if (haddr == ofs_prescale) hrdata <= {22'h0, pre_ff == 9'h000, pre_ff};
                else if (haddr == ofs_multiply) hrdata <= {22'h0, mult_val};
                else if (haddr == ofs_cascade) hrdata <= {{(32 - n_out){1'b0}}, cascade_ff};
                else if (out_index(haddr) < n_out) hrdata <= out_cfg_ff[out_index(haddr)];
                else hrdata <= 32'h00000000;  // unmapped reads as zero
            end
        end
    end

    // pin synchronisers, two flops before any use
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_sync_ff <= 2'b00;
            fb_sync_ff <= 2'b00;
            ref_last_ff <= 1'b0;
            fb_last_ff <= 1'b0;
        end else begin
            ref_sync_ff <= {ref_sync_ff[0], ref_clk};
            fb_sync_ff <= {fb_sync_ff[0], fb_in};
            // last-value flops turn the second stage into a one-cycle edge pulse
            ref_last_ff <= ref_sync_ff[1];
            fb_last_ff <= fb_sync_ff[1];
        end
    end

    // pre-scale: pure frequency divider, one tick per pre_ff reference edges
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_cnt_ff <= 9'h000;
            pre_tick_ff <= 1'b0;
        end else if (loop_hold) begin
            pre_cnt_ff <= 9'h000;
            pre_tick_ff <= 1'b0;
        end else begin
            pre_tick_ff <= 1'b0;
            if (ref_rise) begin
                // >= so a smaller setting written mid-count cannot run past the end
                if (pre_cnt_ff >= pre_ff - 9'h001) begin
                    pre_cnt_ff <= 9'h000;
                    pre_tick_ff <= 1'b1;
                end else begin
                    pre_cnt_ff <= pre_cnt_ff + 9'h001;
                end
            end
        end
    end

    // multiply divider in the feedback path; its square wave is driven out in external feedback mode only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mult_cnt_ff <= 9'h000;
            fb_int_tick_ff <= 1'b0;
            feedback_clock_out_ff <= 1'b0;
            feedback_clock_out <= 1'b0;
        end else if (loop_hold) begin
            mult_cnt_ff <= 9'h000;
            fb_int_tick_ff <= 1'b0;
            feedback_clock_out_ff <= 1'b0;
            feedback_clock_out <= 1'b0;
        end else begin
            fb_int_tick_ff <= 1'b0;
            if (osc_tick) begin
                if (!ext_fb && pre_tick_ff && !fb_int_tick_ff) begin
                    // the loop pulls the oscillator into phase with the reference;
                    // in external mode the board trace closes the loop instead
                    mult_cnt_ff <= 9'h001;
                end else if (mult_cnt_ff >= mult_ff - 9'h001) begin
                    mult_cnt_ff <= 9'h000;
                    fb_int_tick_ff <= 1'b1;
                end else begin
                    mult_cnt_ff <= mult_cnt_ff + 9'h001;
                end
                // half the multiply count high, so the fed-back wave is near 50% duty
                feedback_clock_out_ff <= ({1'b0, mult_cnt_ff} < (mult_val >> 1))
                    || (mult_ff == 9'h001 && ~feedback_clock_out_ff);
            end
            feedback_clock_out <= ext_fb & feedback_clock_out_ff;
        end
    end

    // lock: count feedback edges that land with a pre-scale tick; a miss drops lock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock_cnt_ff <= 5'h00;
            locked <= 1'b0;
        end else if (loop_hold) begin
            lock_cnt_ff <= 5'h00;
            locked <= 1'b0;
        end else begin
            if (pre_tick_ff && fb_tick) begin
                // coincidence: one more aligned edge, saturating at the target
                if (lock_cnt_ff != 5'(lock_cycles)) lock_cnt_ff <= lock_cnt_ff + 5'h01;
            end else if (pre_tick_ff ^ fb_tick) begin
                // a lone edge on either side means the loop slipped: start over
                lock_cnt_ff <= 5'h00;
            end
            // registered so the lock pin never glitches
            locked <= (lock_cnt_ff == 5'(lock_cycles));
        end
    end

    // seven output dividers, each after divider 0 optionally fed by its neighbour
    genvar g;
    generate
        for (g = 0; g < n_out; g++) begin : g_div
            wire src_tick;
            // divider 0 has no neighbour, so it always runs from the oscillator
            if (g == 0) begin : g_first
                assign src_tick = osc_tick;
            end else begin : g_rest
                // cascade multiplies the ratios
                assign src_tick = cascade_ff[g] ? div_tick[g-1] : osc_tick;
            end
            post_divider u_div (
                .hclk(hclk),
                .hresetn(hresetn),
                .hold(loop_hold),
                .tick_in(src_tick),
                .high_m1(out_cfg_ff[g][out_high_lsb +: half_w]),
                .low_m1(out_cfg_ff[g][out_low_lsb +: half_w]),
                .delay(out_cfg_ff[g][out_delay_lsb +: cnt_w]),
                .bypass(out_cfg_ff[g][out_bypass_bit]),
                .clk_out(div_clk[g]),
                .tick_out(div_tick[g])
            );
        end
    endgenerate

    // register the divider outputs for the pins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_clk_out <= '0;
        end else begin
            div_clk_out <= div_clk;
        end
    end
endmodule : pll_counter_synthesis

/* pll_counter_checker.sv */
`timescale 1ns/1ns
module pll_counter_checker
    import pll_counter_pkg::*;
#(
    parameter int n_out = num_outputs
) (
    // system
    input wire logic hclk,
    input wire logic hresetn,
    // bus
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // loop
    input wire logic ref_clk,
    input wire logic fb_in,
    input wire logic [n_out-1:0] div_clk_out,
    input wire logic feedback_clock_out,
    input wire logic locked
);
    logic rd_ff; // read data phase under way
    logic wr_ff; // write data phase under way
    logic [7:0] adr_ff; // address of the data phase
    logic loop_rst_ff; // shadow of the loop reset bit
    logic ext_fb_ff; // shadow of the external feedback bit
    logic [7:0] run_ff; // cycles since loop release, saturating
    // follow the bus phases
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_ff <= 1'b0;
            wr_ff <= 1'b0;
            adr_ff <= 8'h00;
        end else begin
            rd_ff <= hsel && hready && htrans[1] && !hwrite;
            wr_ff <= hsel && hready && htrans[1] && hwrite;
            adr_ff <= haddr;
        end
    end
    // shadow control bits; high bandwidth drop does not matter here
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            loop_rst_ff <= 1'b1;
            ext_fb_ff <= 1'b0;
        end else if (wr_ff && adr_ff == ofs_ctrl) begin
            loop_rst_ff <= hwdata[ctrl_loop_reset_bit];
            ext_fb_ff <= hwdata[ctrl_ext_fb_bit];
        end
    end
    // run time counter, saturates so it never wraps into a false low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_ff <= 8'h00;
        end else if (loop_rst_ff) begin
            run_ff <= 8'h00;
        end else if (run_ff != 8'hFF) begin
            run_ff <= run_ff + 8'h01;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence rd_s(logic [7:0] a);
        rd_ff && adr_ff == a;
    endsequence
    range_read_a: assert property ((rd_s(ofs_prescale) or rd_s(ofs_multiply)) |->
        hrdata >= 32'h1 && hrdata <= 32'h200) else $error("divide value out of range");
    no_div7_a: assert property (rd_s(ofs_out_base + 8'h1C) |-> hrdata == 32'h0)
        else $error("eighth divider word readable");
    bw_combo_a: assert property (rd_s(ofs_ctrl) |-> !(hrdata[1] && hrdata[2]))
        else $error("high bandwidth kept with external feedback");
    lock_status_a: assert property (rd_s(ofs_status) |-> hrdata[0] == locked ||
        hrdata[0] == $past(locked) || hrdata[0] == $past(locked, 2))
        else $error("status lock bit differs from lock output");
    lock_time_a: assert property (!loop_rst_ff [*3] ##0 locked |-> run_ff >= 8'h10)
        else $error("lock too soon after loop release");
    reset_quiet_a: assert property (loop_rst_ff [*3] |-> div_clk_out == '0 && !locked)
        else $error("outputs alive in loop reset");
    lock_drop_a: assert property ($rose(loop_rst_ff) |-> ##[1:3] !locked)
        else $error("lock kept through loop reset");
    feedback_clock_out_mode_a: assert property (!ext_fb_ff [*3] |-> !feedback_clock_out)
        else $error("feedback output active outside external mode");
endmodule : pll_counter_checker
bind pll_counter_synthesis pll_counter_checker #(.n_out(n_out)) chk (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ref_clk(ref_clk), .fb_in(fb_in),
    .div_clk_out(div_clk_out), .feedback_clock_out(feedback_clock_out), .locked(locked));

/* ref_source.sv */
`timescale 1ns/1ns
module ref_source #(
    parameter int half_cycles = 4 // reference half period in hclk cycles
) (
    // system clock
    input wire logic hclk,
    // loop pins
    input wire logic fb_drive,
    output logic ref_clk,
    output logic fb_in
);
    int cnt_ff; // cycles into this half period
    initial begin
        ref_clk = 1'b0;
        fb_in = 1'b0;
        cnt_ff = 0;
    end
    // a crystal runs free, so the reference never stops
    always @(posedge hclk) begin
        if (cnt_ff >= half_cycles - 1) begin
            cnt_ff <= 0;
            ref_clk <= !ref_clk;
        end else begin
            cnt_ff <= cnt_ff + 1;
        end
    end
    // single-ended board trace back to the feedback pin, one cycle late
    always @(posedge hclk) fb_in <= fb_drive;
endmodule : ref_source

/* pll_counter_synthesis_tb_top.sv */
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== 32'(e)) begin num_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, 32'(e)); end end
module pll_counter_synthesis_tb_top import pll_counter_pkg::*; ;
    logic hclk = 1'b0; // system clock
    logic hresetn = 1'b0; // bus reset, active low
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, ref_clk, fb_in, feedback_clock_out, locked, pv;
    logic [num_outputs-1:0] div_clk_out;
    logic [31:0] mdl [0:63]; // register model, index is offset over four
    logic [31:0] r;
    logic cas_done = 1'b0; // cascade word already written once
    int num_errors = 0;
    int num_checks = 0;
    int vals[$] = '{512, 0, 513, 1};
    int hq[num_outputs];
    int lq[num_outputs];
    int hi, lo, k;
    always #25 hclk = ~hclk;
    pll_counter_synthesis uut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ref_clk(ref_clk),
        .fb_in(fb_in), .div_clk_out(div_clk_out), .feedback_clock_out(feedback_clock_out),
        .locked(locked));
    ref_source src (.hclk(hclk), .fb_drive(feedback_clock_out), .ref_clk(ref_clk),
        .fb_in(fb_in));
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    // one single transfer, entered just after a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        n = 0;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
        htrans <= 2'h0;
        if (w) hwdata <= d;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 200);
        r = hrdata;
        if (n >= 200) begin num_errors++; summarize(); end
    endtask : xfer
    // write and update the model with what the block keeps
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
        case (a)
            ofs_ctrl: mdl[0] = (d[2:1] == 2'h3) ? d & 32'h3 : d & 32'h7;
            ofs_prescale, ofs_multiply: if (d >= 1 && d <= 512) mdl[a >> 2] = d;
            ofs_cascade: if (!cas_done) mdl[4] = d & 32'h7E;
            default: if (a >= ofs_out_base && a < 8'h3C) mdl[a >> 2] = d & 32'h81FFFFFF;
        endcase
        if (a == ofs_cascade) cas_done = 1'b1;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        xfer(1'b0, a, 32'h0);
        `CHK(r, mdl[a >> 2])
    endtask : rd
    // a wait that used up its bound ends the run as a failure
    task automatic limit(input int v, input int lim);
        if (v >= lim) begin
            num_errors++;
            summarize();
        end
    endtask : limit
    // one whole period of an output, counted from a rise
    task automatic meas(input int n);
        for (k = 0; k < 5000 && div_clk_out[n] !== 1'b0; k++) @(posedge hclk);
        limit(k, 5000);
        for (k = 0; k < 5000 && div_clk_out[n] !== 1'b1; k++) @(posedge hclk);
        limit(k, 5000);
        hi = 0;
        lo = 0;
        while (div_clk_out[n] === 1'b1 && hi < 5000) begin @(posedge hclk); hi++; end
        while (div_clk_out[n] === 1'b0 && lo < 5000) begin @(posedge hclk); lo++; end
        limit(hi, 5000);
        limit(lo, 5000);
    endtask : meas
    // watchdog so no hang outlives the run budget
    initial begin
        repeat (90000) @(posedge hclk);
        num_errors++;
        summarize();
    end
    initial begin
        void'($urandom(32'h6F4EFADE));
        for (int i = 0; i < 64; i++) mdl[i] = 32'h0;
        mdl[0] = rst_ctrl;
        mdl[2] = 32'(rst_divide);
        mdl[3] = 32'(rst_divide);
        vals.insert(3, $urandom_range(512, 1));
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // every word but status, holes included, after reset
        for (int a = 0; a < 64; a += 4) if (a != 4) rd(8'(a));
        $display("test reset_values done");
        foreach (vals[i]) begin
            wr(ofs_prescale, vals[i]);
            rd(ofs_prescale);
            wr(ofs_multiply, vals[i]);
            rd(ofs_multiply);
        end
        wr(ofs_status, 32'hFFFFFFFF);
        wr(8'h3C, 32'hFFFFFFFF);
        rd(8'h3C);
        wr(ofs_ctrl, 32'h7);
        rd(ofs_ctrl);
        $display("test registers done");
        wr(ofs_cascade, 32'h2);
        wr(ofs_cascade, 32'h0);
        rd(ofs_cascade);
        for (int n = 0; n < num_outputs; n++) begin
            hq[n] = (n == 6) ? 256 : (n == 2) ? 1 : $urandom_range(8, 1);
            lq[n] = (n == 2) ? 1 : $urandom_range(8, 1);
            // divider 2 in bypass, divider 5 starts two counts late
            wr(ofs_out_base + 8'(4 * n), {(n == 2) ? 16'h8000 : (n == 5) ? 16'h0003 : 16'h0000,
                8'(hq[n] - 1), 8'(lq[n] - 1)});
            rd(ofs_out_base + 8'(4 * n));
        end
        wr(ofs_ctrl, 32'h0);
        // first rise of divider 5 trails divider 0 by its start delay less one
        hi = -1;
        lo = -1;
        for (k = 0; k < 100 && lo < 0; k++) begin
            @(posedge hclk);
            if (hi < 0 && div_clk_out[0] === 1'b1) hi = k;
            if (div_clk_out[5] === 1'b1) lo = k;
        end
        limit(k, 100);
        `CHK(lo - hi, 2)
        for (int n = 0; n < num_outputs; n++) begin
            meas(n);
            `CHK(hi, (n == 1) ? hq[1] * (hq[0] + lq[0]) : hq[n])
            `CHK(lo, (n == 1) ? lq[1] * (hq[0] + lq[0]) : lq[n])
        end
        $display("test dividers done");
        // eight oscillator cycles per reference cycle, so feedback meets the reference
        wr(ofs_multiply, 32'h8);
        for (k = 0; k < 3000 && locked !== 1'b1; k++) @(posedge hclk);
        limit(k, 3000);
        `CHK(locked, 1'b1)
        xfer(1'b0, ofs_status, 32'h0);
        `CHK(r[1:0], 2'h3)
        $display("test lock done");
        wr(ofs_multiply, 32'h4);
        wr(ofs_ctrl, 32'h2);
        for (k = 0; k < 500 && feedback_clock_out !== 1'b0; k++) @(posedge hclk);
        limit(k, 500);
        for (k = 0; k < 500 && feedback_clock_out !== 1'b1; k++) @(posedge hclk);
        limit(k, 500);
        k = 0;
        pv = 1'b1;
        repeat (80) begin
            @(posedge hclk);
            k += int'(feedback_clock_out === 1'b1 && pv === 1'b0);
            pv = feedback_clock_out;
        end
        `CHK(k, 20)
        $display("test external_feedback done");
        wr(ofs_ctrl, 32'h1);
        repeat (4) @(posedge hclk);
        `CHK({locked, feedback_clock_out, div_clk_out}, 9'h0)
        rd(ofs_ctrl);
        $display("test loop_reset done");
        summarize();
    end
endmodule : pll_counter_synthesis_tb_top
